// File: rtl/cbt_pkg.sv
package cbt_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_BREAKPOINT_INSTR   = 8'h08;
   localparam logic [7:0] OFF_LINK   = 8'h0c;
   localparam logic [7:0] OFF_STACK  = 8'h10;
   localparam int CTRL_RESUME = 0;
   localparam int CTRL_CLRERR = 1;
   localparam logic [7:0]  BLK_RST  = 8'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   // Return marker value is arbitrary.
   localparam logic [31:0] LINK_MARK = 32'hffff_fff1;
   // ------------------------------------------------------------
   // Opcode patterns
   // ------------------------------------------------------------
   localparam logic [7:0]  OP_PREFIX = 8'hbf;
   localparam logic [7:0]  OP_BREAKPOINT_INSTR   = 8'hbe;
   localparam logic [10:0] OP_MASK   = 11'h5b3;
   localparam logic [3:0]  OP_CB     = 4'hb;
   localparam logic [3:0]  OP_BCOND  = 4'hd;
   localparam logic [2:0]  OP_BC_EXT = 3'h7;
   localparam logic [4:0]  OP_B16    = 5'h1c;
   localparam logic [8:0]  OP_BX     = 9'h08e;
   localparam logic [7:0]  OP_ADDHI  = 8'h44;
   localparam logic [7:0]  OP_MOVHI  = 8'h46;
   localparam logic [7:0]  OP_POPPC  = 8'hbd;
   localparam logic [4:0]  OP_B32    = 5'h1e;
   localparam logic [6:0]  OP_LDR32  = 7'h7c;
   localparam logic [6:0]  OP_LDM32  = 7'h74;
   localparam logic [11:0] OP_TB1    = 12'he8d;
   localparam logic [10:0] OP_TB2    = 11'h780;
   localparam logic [15:0] OP_BAR1   = 16'hf3bf;
   localparam logic [11:0] OP_BAR2   = 12'h8f5;
   localparam logic [3:0]  REG_SP    = 4'hd;
   localparam logic [3:0]  REG_PC    = 4'hf;
   localparam logic [3:0]  COND_AL   = 4'he;
   localparam logic [3:0]  COND_NV   = 4'hf;
   localparam logic [31:0] PC_AHEAD  = 32'h0000_0004;
   typedef enum logic [1:0] {ST_RUN, ST_TABLE, ST_HALT} state_e;
endpackage : cbt_pkg

// File: rtl/cond_block_table_branch_ctrl.sv
// How it works
// [RULE1] Prefix makes one to four following instructions conditional.
// [RULE2] Block instructions use base condition or inverse only.
// [RULE3] Switch bits pick then or else per slot.
// [RULE4] Always-true prefix forbids any else switch.
// [RULE5] Breakpoint inside block executes regardless of condition.
// [RULE6] Exception between or within block saves return state.
// [RULE7] Exception return restores block state and resumes.
// [RULE8] Nested prefix, compare-branch, mask change refused inside.
// [RULE9] PC writers only outside or last in block.
// [RULE10] Only conditional branch may be conditional outside block.
// [RULE11] Prefix and breakpoint leave flags unchanged.
// [RULE12] Table address is base plus scaled index.
// [RULE13] Table branch target is next address plus twice entry.
// [RULE14] PC base means table follows the instruction.
// [RULE15] Stack pointer base, SP or PC index refused.
// [RULE16] Breakpoint halts core; immediate kept for debugger.
// [RULE17] Mask change clears or sets selected mask bits.
// [RULE18] Fault mask blocks all faults; primary only configurable.
// [RULE19] Mask change ignored unprivileged, unconditional, flags kept.
// [RULE20] Barrier holds later memory accesses until earlier complete.
// [RULE21] Barrier never holds instructions without memory access.
// [RULE22] Block state holds condition and pattern, advances, clears.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cond_block_table_branch_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire logic        instr_valid,
   output logic             instr_ready,
   input  wire logic [31:0] instr_word,
   input  wire logic        instr_wide,
   input  wire logic        instr_mem,
   input  wire logic [31:0] instr_addr,
   input  wire logic [3:0]  flags_nzcv,
   input  wire logic        privileged,
   input  wire logic [31:0] base_val,
   input  wire logic [31:0] index_val,
   input  wire logic        mem_busy,
   output logic             tbl_req,
   output logic             tbl_half,
   output logic [31:0]      tbl_addr,
   input  wire logic        tbl_ack,
   input  wire logic [15:0] tbl_data,
   input  wire logic        exc_req,
   input  wire logic        exc_ret,
   input  wire logic [31:0] exc_ret_psw,
   output logic             exc_taken,
   output logic [31:0]      link_register,
   output logic [31:0]      program_status_word,
   output logic             res_valid,
   output logic             res_exec,
   output logic             res_illegal,
   output logic             res_flags_keep,
   output logic             res_branch,
   output logic [31:0]      res_target,
   output logic             debug_halt,
   output logic             primary_irq_mask,
   output logic             fault_irq_mask,
   output logic             irq_block,
   output logic             cfg_fault_block,
   output logic             all_fault_block
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic cond_pass(input logic [3:0] c,
                                      input logic [3:0] f);
      logic r;
      r = 1'b0;
      unique case (c[3:1])
         3'h0: r = f[2];
         3'h1: r = f[1];
         3'h2: r = f[3];
         3'h3: r = f[0];
         3'h4: r = f[1] & ~f[2];
         3'h5: r = f[3] == f[0];
         3'h6: r = ~f[2] & (f[3] == f[0]);
         3'h7: r = 1'b1;
      endcase
      if (c[3:1] != 3'h7 && c[0]) begin
         r = ~r;
      end
      return r;
   endfunction : cond_pass

   function automatic logic [31:0] psw_pack(input logic [7:0] b);
      return {5'h00, b[1:0], 9'h000, b[7:2], 10'h000};
   endfunction : psw_pack

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   cbt_pkg::state_e st_q;
   logic [7:0]  blk_q;
   logic [7:0]  blk_next;
   logic [15:0] hw1;
   logic [15:0] hw2;
   logic        in_blk;
   logic        last_blk;
   logic        is_pfx;
   logic        is_cb;
   logic        is_breakpoint_instr;
   logic        is_mask;
   logic        is_bc;
   logic        is_tb;
   logic        is_bar;
   logic        pc_wr;
   logic        illegal;
   logic        pass;
   logic        execs;
   logic        accept;
   logic [31:0] tb_base;
   logic        bar_q;
   logic        err_q;
   logic [7:0]  imm_q;
   logic [31:0] tb_pc_q;

   always_comb begin
      hw1      = instr_wide ? instr_word[31:16] : instr_word[15:0];
      hw2      = instr_word[15:0];
      in_blk   = blk_q[3:0] != 4'h0;
      last_blk = blk_q[3:0] == 4'h8;
      is_pfx   = !instr_wide && hw1[15:8] == cbt_pkg::OP_PREFIX
                 && hw1[3:0] != 4'h0;
      is_cb    = !instr_wide && hw1[15:12] == cbt_pkg::OP_CB
                 && !hw1[10] && hw1[8];
      is_breakpoint_instr  = !instr_wide && hw1[15:8] == cbt_pkg::OP_BREAKPOINT_INSTR;
      is_mask  = !instr_wide && hw1[15:5] == cbt_pkg::OP_MASK;
      is_bc    = !instr_wide && hw1[15:12] == cbt_pkg::OP_BCOND
                 && hw1[11:9] != cbt_pkg::OP_BC_EXT;
      is_tb    = instr_wide && hw1[15:4] == cbt_pkg::OP_TB1
                 && hw2[15:5] == cbt_pkg::OP_TB2;
      is_bar   = instr_wide && hw1 == cbt_pkg::OP_BAR1
                 && hw2[15:4] == cbt_pkg::OP_BAR2;
      pc_wr = is_bc | is_tb;
      if (!instr_wide) begin
         pc_wr = pc_wr | hw1[15:11] == cbt_pkg::OP_B16
                 | hw1[15:8] == cbt_pkg::OP_BX[8:1]
                 | hw1[15:8] == cbt_pkg::OP_POPPC
                 | ((hw1[15:8] == cbt_pkg::OP_ADDHI
                     || hw1[15:8] == cbt_pkg::OP_MOVHI)
                    && {hw1[7], hw1[2:0]} == cbt_pkg::REG_PC);
      end else begin
         // Barriers and special moves share this space but keep the PC.
         pc_wr = pc_wr | (hw1[15:11] == cbt_pkg::OP_B32 && hw2[15]
                          && (hw2[12] || hw1[9:7] != 3'h7))
                 | (hw1[15:9] == cbt_pkg::OP_LDR32 && hw1[4]
                    && hw2[15:12] == cbt_pkg::REG_PC)
                 | (hw1[15:9] == cbt_pkg::OP_LDM32 && hw1[4] && hw2[15]);
      end
      illegal = 1'b0;
      if (in_blk && (is_pfx || is_cb || is_mask)) begin
         illegal = 1'b1; // [RULE8]
      end
      if (in_blk && pc_wr && !last_blk) begin
         illegal = 1'b1; // [RULE9]
      end
      if (in_blk && is_bc && hw1[11:8] != blk_q[7:4]) begin
         illegal = 1'b1; // [RULE2]
      end
      if (is_pfx && (hw1[7:4] == cbt_pkg::COND_NV
          || (hw1[7:4] == cbt_pkg::COND_AL
              && (hw1[3:0] & (hw1[3:0] - 4'h1)) != 4'h0))) begin
         illegal = 1'b1; // [RULE4]
      end
      if (is_tb && (hw1[3:0] == cbt_pkg::REG_SP
          || hw2[3:0] == cbt_pkg::REG_SP
          || hw2[3:0] == cbt_pkg::REG_PC)) begin
         illegal = 1'b1; // [RULE15]
      end
      // Outside a block only the conditional branch carries a condition.
      if (in_blk) begin
         pass = cond_pass(blk_q[7:4], flags_nzcv); // [RULE2]
      end else if (is_bc) begin
         pass = cond_pass(hw1[11:8], flags_nzcv); // [RULE10]
      end else begin
         pass = 1'b1;
      end
      execs = !illegal && (pass || is_breakpoint_instr); // [RULE5]
      tb_base = hw1[3:0] == cbt_pkg::REG_PC
                ? instr_addr + cbt_pkg::PC_AHEAD : base_val; // [RULE14]
      if (blk_q[2:0] == 3'h0) begin
         blk_next = cbt_pkg::BLK_RST; // [RULE22]
      end else begin
         blk_next = {blk_q[7:5], blk_q[3:0], 1'b0}; // [RULE22]
      end
   end

   // A later memory access waits on the barrier; others run on.
   assign instr_ready = st_q == cbt_pkg::ST_RUN && !exc_req && !exc_ret
                        && !(bar_q && instr_mem); // [RULE21]
   assign accept = instr_valid && instr_ready;

   // ------------------------------------------------------------
   // Block state and exceptions
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_q <= cbt_pkg::BLK_RST;
      end else if (exc_ret && st_q == cbt_pkg::ST_RUN) begin
         blk_q <= {exc_ret_psw[15:10], exc_ret_psw[26:25]}; // [RULE7]
      end else if (exc_req && st_q == cbt_pkg::ST_RUN) begin
         blk_q <= cbt_pkg::BLK_RST; // [RULE6]
      end else if (accept && is_pfx && !illegal) begin
         blk_q <= hw1[7:0]; // [RULE1] [RULE3]
      end else if (accept && in_blk) begin
         blk_q <= blk_next; // [RULE22]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exc_taken           <= 1'b0;
         link_register       <= cbt_pkg::WORD_RST;
         program_status_word <= cbt_pkg::WORD_RST;
      end else begin
         exc_taken <= exc_req && !exc_ret && st_q == cbt_pkg::ST_RUN;
         if (exc_req && !exc_ret && st_q == cbt_pkg::ST_RUN) begin
            link_register       <= cbt_pkg::LINK_MARK; // [RULE6]
            program_status_word <= psw_pack(blk_q); // [RULE6]
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencing, table branch and breakpoint
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= cbt_pkg::ST_RUN;
         tbl_req  <= 1'b0;
         tbl_half <= 1'b0;
         tbl_addr <= cbt_pkg::WORD_RST;
         tb_pc_q  <= cbt_pkg::WORD_RST;
         imm_q    <= cbt_pkg::BLK_RST;
      end else begin
         unique case (st_q)
            cbt_pkg::ST_RUN: begin
               if (accept && execs && is_tb) begin
                  st_q     <= cbt_pkg::ST_TABLE;
                  tbl_req  <= 1'b1;
                  tbl_half <= hw2[4];
                  tbl_addr <= tb_base + (hw2[4] ? {index_val[30:0], 1'b0}
                                                : index_val); // [RULE12]
                  tb_pc_q  <= instr_addr + cbt_pkg::PC_AHEAD;
               end else if (accept && execs && is_breakpoint_instr) begin
                  st_q  <= cbt_pkg::ST_HALT; // [RULE16]
                  imm_q <= hw1[7:0]; // [RULE16]
               end
            end
            cbt_pkg::ST_TABLE: begin
               if (tbl_ack) begin
                  st_q    <= cbt_pkg::ST_RUN;
                  tbl_req <= 1'b0;
               end
            end
            cbt_pkg::ST_HALT: begin
               if (psel && penable && pwrite && paddr == cbt_pkg::OFF_CTRL
                   && pwdata[cbt_pkg::CTRL_RESUME]) begin
                  st_q <= cbt_pkg::ST_RUN;
               end
            end
         endcase
      end
   end
   assign debug_halt = st_q == cbt_pkg::ST_HALT;

   // ------------------------------------------------------------
   // Results
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_valid      <= 1'b0;
         res_exec       <= 1'b0;
         res_illegal    <= 1'b0;
         res_flags_keep <= 1'b0;
         res_branch     <= 1'b0;
         res_target     <= cbt_pkg::WORD_RST;
      end else if (st_q == cbt_pkg::ST_TABLE) begin
         res_valid  <= tbl_ack;
         res_branch <= tbl_ack;
         if (tbl_ack) begin
            res_target <= tb_pc_q + {15'h0000, (tbl_half ? tbl_data
                          : {8'h00, tbl_data[7:0]}), 1'b0}; // [RULE13]
         end
      end else begin
         res_valid      <= accept && !(execs && is_tb);
         res_exec       <= execs;
         res_illegal    <= illegal;
         res_branch     <= 1'b0;
         res_flags_keep <= is_pfx | is_breakpoint_instr | is_mask | is_tb | is_bar
                           | is_cb | is_bc; // [RULE11] [RULE15] [RULE19]
      end
   end

   // ------------------------------------------------------------
   // Interrupt masks
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primary_irq_mask <= 1'b0;
         fault_irq_mask   <= 1'b0;
      end else if (accept && is_mask && !illegal && privileged) begin
         if (hw1[1]) begin
            primary_irq_mask <= hw1[4]; // [RULE17] [RULE19]
         end
         if (hw1[0]) begin
            fault_irq_mask <= hw1[4]; // [RULE17] [RULE19]
         end
      end
   end
   assign irq_block       = primary_irq_mask | fault_irq_mask; // [RULE18]
   assign cfg_fault_block = primary_irq_mask | fault_irq_mask; // [RULE18]
   assign all_fault_block = fault_irq_mask; // [RULE18]

   // ------------------------------------------------------------
   // Memory barrier
   // ------------------------------------------------------------
   // Only outstanding accesses hold the barrier, so it costs nothing
   // when the memory side is already idle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bar_q <= 1'b0;
      end else if (accept && execs && is_bar) begin
         bar_q <= mem_busy; // [RULE20]
      end else if (!mem_busy) begin
         bar_q <= 1'b0; // [RULE20]
      end
   end

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   logic mapped;
   assign mapped = paddr == cbt_pkg::OFF_CTRL || paddr == cbt_pkg::OFF_STATUS
                   || paddr == cbt_pkg::OFF_BREAKPOINT_INSTR || paddr == cbt_pkg::OFF_LINK
                   || paddr == cbt_pkg::OFF_STACK;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // A new refusal wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (accept && illegal) begin
         err_q <= 1'b1;
      end else if (psel && penable && pwrite && paddr == cbt_pkg::OFF_CTRL
                   && pwdata[cbt_pkg::CTRL_CLRERR]) begin
         err_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= cbt_pkg::WORD_RST;
      end else if (psel && !penable) begin
         unique case (paddr)
            cbt_pkg::OFF_STATUS: prdata <= {18'h00000,
               st_q == cbt_pkg::ST_TABLE, err_q, bar_q, debug_halt,
               fault_irq_mask, primary_irq_mask, blk_q};
            cbt_pkg::OFF_BREAKPOINT_INSTR:  prdata <= {24'h000000, imm_q};
            cbt_pkg::OFF_LINK:  prdata <= link_register;
            cbt_pkg::OFF_STACK: prdata <= program_status_word;
            default:            prdata <= cbt_pkg::WORD_RST;
         endcase
      end
   end
endmodule : cond_block_table_branch_ctrl
`default_nettype wire

// File: sim/cbt_checker_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cbt_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        instr_valid,
   input wire logic        instr_ready,
   input wire logic [31:0] instr_word,
   input wire logic        instr_wide,
   input wire logic        privileged,
   input wire logic        tbl_req,
   input wire logic [31:0] tbl_addr,
   input wire logic        tbl_ack,
   input wire logic        exc_taken,
   input wire logic [31:0] link_register,
   input wire logic        res_valid,
   input wire logic        res_branch,
   input wire logic        debug_halt,
   input wire logic        primary_irq_mask,
   input wire logic        fault_irq_mask,
   input wire logic        irq_block,
   input wire logic        cfg_fault_block,
   input wire logic        all_fault_block
);
   // ------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic take = instr_valid && instr_ready && !instr_wide;
   property p_tbl_hold;
      tbl_req && !tbl_ack |=> tbl_req && $stable(tbl_addr);
   endproperty
   a_tbl_hold: assert property (p_tbl_hold) else $error("table request dropped");
   property p_tbl_done;
      tbl_req && tbl_ack |=> res_valid && res_branch && !tbl_req;
   endproperty
   a_tbl_done: assert property (p_tbl_done) else $error("table branch not done");
   property p_exc_link;
      $rose(exc_taken) |-> link_register == cbt_pkg::LINK_MARK;
   endproperty
   a_exc_link: assert property (p_exc_link) else $error("bad return marker");
   property p_irq;
      irq_block == (primary_irq_mask || fault_irq_mask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq block wrong");
   property p_cfg;
      cfg_fault_block == (primary_irq_mask || fault_irq_mask);
   endproperty
   a_cfg: assert property (p_cfg) else $error("cfg fault block wrong");
   property p_all;
      all_fault_block == fault_irq_mask;
   endproperty
   a_all: assert property (p_all) else $error("all fault block wrong");
   property p_unpriv;
      take && instr_word[15:5] == cbt_pkg::OP_MASK && !privileged
         |=> $stable(primary_irq_mask) && $stable(fault_irq_mask);
   endproperty
   a_unpriv: assert property (p_unpriv) else $error("unprivileged mask change");
   property p_breakpoint_instr;
      take && instr_word[15:8] == cbt_pkg::OP_BREAKPOINT_INSTR |=> debug_halt;
   endproperty
   a_breakpoint_instr: assert property (p_breakpoint_instr) else $error("breakpoint did not halt");
   property p_halt;
      debug_halt |-> !instr_ready;
   endproperty
   a_halt: assert property (p_halt) else $error("accepting while halted");
endmodule : cbt_monitor
bind cond_block_table_branch_ctrl cbt_monitor cbt_monitor_inst (.*);
`default_nettype wire

// File: sim/tbl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbl_mem_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        tbl_req,
   input  wire logic        tbl_half,
   input  wire logic [31:0] tbl_addr,
   input  wire logic [3:0]  tbl_delay,
   output logic             tbl_ack,
   output logic [15:0]      tbl_data
);
   // ------------------------------------------------------------
   // Table memory
   // ------------------------------------------------------------
   // Data toggles between answers, so a stale entry can never match.
   logic [3:0] wait_q;
   wire logic  hit = tbl_req && !tbl_ack && wait_q == tbl_delay;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q   <= 4'h0;
         tbl_ack  <= 1'b0;
         tbl_data <= 16'h0f0f;
      end else begin
         tbl_ack  <= hit;
         wait_q   <= (tbl_req && !tbl_ack && !hit) ? wait_q + 4'h1 : 4'h0;
         tbl_data <= hit ? {tbl_half ? tbl_addr[7:0] ^ 8'h33 : 8'h00, tbl_addr[7:0] ^ 8'h5a}
                         : ~tbl_data;
      end
   end
endmodule : tbl_mem_model
`default_nettype wire

// File: sim/cond_block_table_branch_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module cond_block_table_branch_ctrl_test;
   // ------------------------------------------------------------
   // Bench
   // ------------------------------------------------------------
   localparam logic [15:0] MW [4] = '{16'hb672, 16'hb671, 16'hb663, 16'hb673};
   localparam logic [4:0]  ME [4] = '{5'h1a, 5'h1f, 5'h00, 5'h00};
   localparam logic [31:0] IL [8] = '{32'hbf08, 32'hb100, 32'hb672, 32'he000,
                                      32'he8ddf001, 32'he8d0f00d, 32'he8d0f00f, 32'hd1fe};
   localparam logic [31:0] TW [2] = '{32'he8d0f001, 32'he8dff012};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, instr_word = 32'h0, instr_addr = 32'h400, base_val = 32'h0;
   logic [31:0] index_val = 32'h0, exc_ret_psw = 32'h0, prdata, tbl_addr, res_target;
   logic [31:0] link_register, program_status_word, rd, t_addr, r_tgt, ta, psw;
   logic        instr_valid = 1'b0, instr_wide = 1'b0, instr_mem = 1'b0, privileged = 1'b1;
   logic        mem_busy = 1'b0, exc_req = 1'b0, exc_ret = 1'b0, pready, pslverr, err;
   logic        instr_ready, tbl_req, tbl_half, tbl_ack, exc_taken, res_valid, res_exec;
   logic        res_illegal, res_flags_keep, res_branch, debug_halt, primary_irq_mask;
   logic        fault_irq_mask, irq_block, cfg_fault_block, all_fault_block;
   logic        r_exec, r_ill, r_keep, r_br;
   logic [3:0]  flags_nzcv = 4'h4, tbl_delay = 4'h0;
   logic [15:0] tbl_data, ent;
   int          fails = 0, n_checks = 0;
   always #2.5 pclk = ~pclk;
   cond_block_table_branch_ctrl cond_block_table_branch_ctrl_inst (.*);
   tbl_mem_model tbl_mem_model_inst (.*);
   task automatic summarize();
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         $display("mismatch %0t got %h exp %h", $time, g, e);
         fails++;
      end
   endtask : chk
   task automatic tmo(input int i, input int lim);
      if (i >= lim) begin
         $display("mismatch %0t wait ran out", $time);
         fails++;
         summarize();
      end
   endtask : tmo
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 32);
      tmo(i, 32);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic issue(input logic [31:0] w, input logic wd);
      int i;
      instr_word  <= w;
      instr_wide  <= wd;
      instr_valid <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (instr_ready !== 1'b1 && i < 64);
      tmo(i, 64);
      instr_valid <= 1'b0;
      do begin
         @(posedge pclk);
         if (tbl_req === 1'b1) t_addr = tbl_addr;
         i++;
      end while (res_valid !== 1'b1 && i < 128);
      tmo(i, 128);
      r_exec = res_exec;
      r_ill = res_illegal;
      r_keep = res_flags_keep;
      r_br = res_branch;
      r_tgt = res_target;
   endtask : issue
   initial begin
      int k;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h40, 32'h1);
      chk(32'(err), 32'h1);
      for (k = 0; k < 4; k++) begin
         privileged <= (k < 3);
         issue(32'(MW[k]), 1'b0);
         chk(32'({irq_block, cfg_fault_block, all_fault_block, primary_irq_mask,
                  fault_irq_mask}), 32'(ME[k]));
      end
      privileged <= 1'b1;
      issue(32'hbf06, 1'b0);
      chk(32'(r_keep), 32'h1);
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[7:0]), 32'h6);
      for (k = 0; k < 4; k++) begin
         issue(32'h1840, 1'b0);
         chk(32'(r_exec), 32'(k != 2));
      end
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[7:0]), 32'h0);
      for (k = 0; k < 8; k++) begin
         issue((k == 3) ? 32'hbf04 : 32'hbfe8, 1'b0);
         issue(IL[k], IL[k][31]);
         chk(32'({r_ill, r_exec}), 32'h2);
         if (k == 3) issue(32'h1840, 1'b0);
      end
      chk(32'(primary_irq_mask), 32'h0);
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[12]), 32'h1);
      apb(1'b1, cbt_pkg::OFF_CTRL, 32'h2);
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[12]), 32'h0);
      issue(32'hbfec, 1'b0);
      chk(32'(r_ill), 32'h1);
      issue(32'h1840, 1'b0);
      issue(32'h1840, 1'b0);
      issue(32'hd0fe, 1'b0);
      chk(32'({r_ill, r_exec}), 32'h1);
      issue(32'hbf18, 1'b0);
      issue(32'hbeab, 1'b0);
      chk(32'({debug_halt, r_exec, r_keep}), 32'h7);
      apb(1'b0, cbt_pkg::OFF_BREAKPOINT_INSTR, 32'h0);
      chk(32'(rd[7:0]), 32'hab);
      apb(1'b1, cbt_pkg::OFF_CTRL, 32'h1);
      chk(32'(debug_halt), 32'h0);
      for (k = 0; k < 2; k++) begin
         base_val  <= 32'h2000_0100;
         index_val <= k ? 32'h3 : 32'h5;
         tbl_delay <= k ? 4'h5 : 4'h0;
         issue(TW[k], 1'b1);
         ta = k ? 32'h40a : 32'h2000_0105;
         ent = k ? {ta[7:0] ^ 8'h33, ta[7:0] ^ 8'h5a} : {8'h00, ta[7:0] ^ 8'h5a};
         chk(t_addr, ta);
         chk(r_tgt, 32'h404 + 32'({ent, 1'b0}));
         chk(32'({r_br, r_keep}), 32'h3);
      end
      issue(32'hbf04, 1'b0);
      issue(32'h1840, 1'b0);
      exc_req <= 1'b1;
      @(posedge pclk);
      exc_req <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (exc_taken !== 1'b1 && k < 16);
      tmo(k, 16);
      psw = program_status_word;
      chk(link_register, cbt_pkg::LINK_MARK);
      chk(psw, 32'h0000_0800);
      apb(1'b0, cbt_pkg::OFF_STATUS, 32'h0);
      chk(32'(rd[7:0]), 32'h0);
      flags_nzcv  <= 4'h0;
      exc_ret_psw <= psw;
      exc_ret     <= 1'b1;
      @(posedge pclk);
      exc_ret <= 1'b0;
      issue(32'h1840, 1'b0);
      chk(32'(r_exec), 32'h0);
      issue(32'h1840, 1'b0);
      chk(32'(r_exec), 32'h1);
      flags_nzcv <= 4'h4;
      mem_busy   <= 1'b1;
      issue(32'hf3bf8f55, 1'b1);
      issue(32'h1840, 1'b0);
      chk(32'(r_exec), 32'h1);
      instr_mem   <= 1'b1;
      instr_word  <= 32'h6808;
      instr_valid <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(32'(instr_ready), 32'h0);
      mem_busy <= 1'b0;
      issue(32'h6808, 1'b0);
      instr_mem <= 1'b0;
      summarize();
   end
endmodule : cond_block_table_branch_ctrl_test
`default_nettype wire
